// file: iics_pkg.sv
package iics_pkg;
    // link side widths
    localparam int IR_W = 4;
    localparam int DR_W = 16;
    localparam int DW   = 8;
    localparam int AW   = 3;
    localparam int DATA_LSB = 0;
    localparam int ADDR_LSB = 8;

    // instruction codes
    localparam logic [3:0] OP_ENTER      = 4'h1;
    localparam logic [3:0] OP_EXIT       = 4'h2;
    localparam logic [3:0] OP_LOAD_CLAMP = 4'h3;
    localparam logic [3:0] OP_CLAMP_ON   = 4'h4;
    localparam logic [3:0] OP_ERASE_CFG  = 4'h5;
    localparam logic [3:0] OP_ERASE_USR  = 4'h6;
    localparam logic [3:0] OP_PROG_CFG   = 4'h7;
    localparam logic [3:0] OP_PROG_USR   = 4'h8;
    localparam logic [3:0] OP_READ_CFG   = 4'h9;
    localparam logic [3:0] OP_READ_USR   = 4'hA;
    localparam logic [3:0] OP_SECURE     = 4'hB;
    localparam logic [3:0] OP_COMPLETE   = 4'hC;
    localparam logic [3:0] OP_RELOAD     = 4'hD;
    localparam logic [3:0] OP_BYPASS     = 4'hF;
    localparam logic [3:0] IR_RESET      = 4'hF;

    // per-pin clamp selection codes
    localparam logic [1:0] CLAMP_SAMPLE = 2'h0;
    localparam logic [1:0] CLAMP_HIGH   = 2'h1;
    localparam logic [1:0] CLAMP_LOW    = 2'h2;
    localparam logic [1:0] CLAMP_HIZ    = 2'h3;

    localparam logic [7:0] FLASH_ERASED = 8'hFF;
    localparam logic [7:0] SIG_RESET    = 8'h00;

    // timing
    localparam int CLK_MHZ     = 10;
    localparam int T_CONFIG_US = 450;
    localparam int T_CONFIG_CYC = T_CONFIG_US * CLK_MHZ;

    typedef enum logic [3:0] {
        TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3, TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5,
        TAP_PS_DR  = 4'h6, TAP_EX2_DR = 4'h7, TAP_UP_DR  = 4'h8,
        TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR  = 4'hB,
        TAP_EX1_IR = 4'hC, TAP_PS_IR  = 4'hD, TAP_EX2_IR = 4'hE,
        TAP_UP_IR  = 4'hF
    } iics_tap_t;
endpackage

// file: iics_sync2.sv
`timescale 1ns/100ps
module iics_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        meta  <= d_in;
        q_out <= meta;
    end
endmodule // iics_sync2

// file: iics_top.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - entering programming without clamp floats pins with pull-ups
// - clamp samples output pin and holds it
// - sampled input pin stays high impedance
// - clamp can force high, low or hiz
// - clamp choice selected per pin
// - config flash rewritable while design keeps running
// - new image takes effect at next load
// - reload instruction reloads SRAM without power cycle
// - pins float with pull-ups during reload
// - security bit blocks config flash readback
// - security bit cleared only by erase
// - SRAM configuration never readable
// - security bit leaves user flash accessible
// - user flash reachable from link and logic
// - pins stay undriven until completion bit programmed, except pins clamped in programming
module iics_top
    import iics_pkg::*;
#(
    parameter int NPIN     = 8,
    parameter int DEPTH    = 8,
    parameter int TCFG_CYC = iics_pkg::T_CONFIG_CYC
) (
    input  wire logic            clock_in,
    input  wire logic            rst_in,
    input  wire logic            tck_in,
    input  wire logic            tms_in,
    input  wire logic            tdi_in,
    output logic                 tdo_out,
    output logic                 tdo_oe_out,
    input  wire logic [NPIN-1:0] pin_in,
    output logic      [NPIN-1:0] pin_out,
    output logic      [NPIN-1:0] pin_oe_out,
    output logic      [NPIN-1:0] pin_pullup_out,
    input  wire logic [NPIN-1:0] user_data_in,
    input  wire logic [NPIN-1:0] user_oe_in,
    input  wire logic [AW-1:0]   uf_addr_in,
    input  wire logic            uf_wr_in,
    input  wire logic [DW-1:0]   uf_wdata_in,
    output logic      [DW-1:0]   uf_rdata_out,
    output logic      [DW-1:0]   design_sig_out,
    output logic                 reloading_out,
    output logic                 isp_mode_out,
    output logic                 secure_out,
    output logic                 complete_out
);
    import iics_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // link domain: tap, instruction and data shift paths
    logic            link_rst;
    iics_tap_t       tap;
    iics_tap_t       next_tap;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [DR_W-1:0] dr_sh;
    logic [IR_W-1:0] cmd_op;
    logic [DR_W-1:0] cmd_dr;
    logic            req_tgl;
    logic            ack_link;
    logic [DW-1:0]   rd_data;
    logic            busy;
    logic            fire_ir;
    logic            fire_dr;
    logic            dr_op;
    logic            sh_dr_op;

    iics_sync2 #(.W(1)) u_rst_sync (
        .clk_in (tck_in),
        .d_in   (rst_in),
        .q_out  (link_rst)
    );

    always_comb begin
        next_tap = tap;
        case (tap)
            TAP_RESET:  next_tap = tms_in ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   next_tap = tms_in ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap = tms_in ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tap = tms_in ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  next_tap = tms_in ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: next_tap = tms_in ? TAP_UP_DR  : TAP_PS_DR;
            TAP_PS_DR:  next_tap = tms_in ? TAP_EX2_DR : TAP_PS_DR;
            TAP_EX2_DR: next_tap = tms_in ? TAP_UP_DR  : TAP_SH_DR;
            TAP_UP_DR:  next_tap = tms_in ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tap = tms_in ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: next_tap = tms_in ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  next_tap = tms_in ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: next_tap = tms_in ? TAP_UP_IR  : TAP_PS_IR;
            TAP_PS_IR:  next_tap = tms_in ? TAP_EX2_IR : TAP_PS_IR;
            TAP_EX2_IR: next_tap = tms_in ? TAP_UP_IR  : TAP_SH_IR;
            TAP_UP_IR:  next_tap = tms_in ? TAP_SEL_DR : TAP_IDLE;
            default:    next_tap = TAP_RESET;
        endcase
    end

    always_ff @(posedge tck_in) begin
        if (link_rst) begin
            tap <= TAP_RESET;
        end else begin
            tap <= next_tap;
        end
    end

    always_ff @(posedge tck_in) begin
        if (link_rst || tap == TAP_RESET) begin
            ir_sh <= IR_RESET;
            ir    <= IR_RESET;
        end else if (tap == TAP_CAP_IR) begin
            ir_sh <= 4'h1;
        end else if (tap == TAP_SH_IR) begin
            ir_sh <= {tdi_in, ir_sh[IR_W-1:1]};
        end else if (tap == TAP_UP_IR) begin
            ir <= ir_sh;
        end
    end

    // no instruction captures SRAM contents, so it can never be shifted out
    always_ff @(posedge tck_in) begin
        if (link_rst) begin
            dr_sh <= '0;
        end else if (tap == TAP_CAP_DR) begin
            dr_sh <= {{(DR_W-DW){1'b0}}, rd_data};
        end else if (tap == TAP_SH_DR) begin
            dr_sh <= {tdi_in, dr_sh[DR_W-1:1]};
        end
    end

    always_ff @(posedge tck_in) begin
        if (link_rst) begin
            tdo_out    <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else begin
            tdo_out    <= (tap == TAP_SH_IR) ? ir_sh[0] : dr_sh[0];
            tdo_oe_out <= (next_tap == TAP_SH_IR) || (next_tap == TAP_SH_DR);
        end
    end

    assign dr_op = (ir == OP_LOAD_CLAMP) || (ir == OP_PROG_CFG) ||
                   (ir == OP_PROG_USR) || (ir == OP_READ_CFG) ||
                   (ir == OP_READ_USR);
    assign sh_dr_op = (ir_sh == OP_LOAD_CLAMP) || (ir_sh == OP_PROG_CFG) ||
                      (ir_sh == OP_PROG_USR) || (ir_sh == OP_READ_CFG) ||
                      (ir_sh == OP_READ_USR);
    assign busy    = req_tgl != ack_link;
    // data-register ops wait for Update-DR, or they would run on stale data
    assign fire_ir = (tap == TAP_UP_IR) && (ir_sh != OP_BYPASS) && !sh_dr_op;
    assign fire_dr = (tap == TAP_UP_DR) && dr_op;

    // a request made while the previous one is in flight is dropped
    always_ff @(posedge tck_in) begin
        if (link_rst) begin
            req_tgl <= 1'b0;
            cmd_op  <= OP_BYPASS;
            cmd_dr  <= '0;
        end else if (!busy && (fire_ir || fire_dr)) begin
            req_tgl <= ~req_tgl;
            cmd_op  <= fire_ir ? ir_sh : ir;
            cmd_dr  <= dr_sh;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // crossings: toggle request one way, toggle acknowledge back
    logic req_sys;
    logic req_seen;
    logic ack_tgl;
    logic new_cmd;

    iics_sync2 #(.W(1)) u_req_sync (
        .clk_in (clock_in),
        .d_in   (req_tgl),
        .q_out  (req_sys)
    );

    iics_sync2 #(.W(1)) u_ack_sync (
        .clk_in (tck_in),
        .d_in   (ack_tgl),
        .q_out  (ack_link)
    );

    assign new_cmd = req_sys != req_seen;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            req_seen <= 1'b0;
            ack_tgl  <= 1'b0;
        end else if (new_cmd) begin
            req_seen <= req_sys;
            ack_tgl  <= req_sys;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // system domain: flash arrays, security, completion and reload
    logic [DW-1:0]     cfg_flash [DEPTH];
    logic [DW-1:0]     usr_flash [DEPTH];
    logic [AW-1:0]     cmd_addr;
    logic [DW-1:0]     cmd_data;
    logic [31:0]       cfg_cnt;
    logic [2*NPIN-1:0] clamp_sel;
    logic              clamp_on;
    logic [NPIN-1:0]   held_lvl;
    logic [NPIN-1:0]   was_out;
    logic [NPIN-1:0]   pin_s;

    assign cmd_addr = cmd_dr[ADDR_LSB +: AW];
    assign cmd_data = cmd_dr[DATA_LSB +: DW];

    iics_sync2 #(.W(NPIN)) u_pin_sync (
        .clk_in (clock_in),
        .d_in   (pin_in),
        .q_out  (pin_s)
    );

    // reset stands for a blank part: arrays erased, both flag bits clear
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                cfg_flash[i] <= FLASH_ERASED;
                usr_flash[i] <= FLASH_ERASED;
            end
        end else if (new_cmd && isp_mode_out) begin
            case (cmd_op)
                OP_ERASE_CFG: begin
                    for (int i = 0; i < DEPTH; i++) begin
                        cfg_flash[i] <= FLASH_ERASED;
                    end
                end
                OP_ERASE_USR: begin
                    for (int i = 0; i < DEPTH; i++) begin
                        usr_flash[i] <= FLASH_ERASED;
                    end
                end
                // programming only clears bits; design keeps running
                OP_PROG_CFG: begin
                    cfg_flash[cmd_addr] <= cfg_flash[cmd_addr] & cmd_data;
                end
                OP_PROG_USR: begin
                    usr_flash[cmd_addr] <= usr_flash[cmd_addr] & cmd_data;
                end
                default: begin
                end
            endcase
        end else if (uf_wr_in) begin
            usr_flash[uf_addr_in] <= usr_flash[uf_addr_in] & uf_wdata_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            secure_out   <= 1'b0;
            complete_out <= 1'b0;
        end else if (new_cmd && isp_mode_out) begin
            if (cmd_op == OP_ERASE_CFG) begin
                secure_out   <= 1'b0;
                complete_out <= 1'b0;
            end else if (cmd_op == OP_SECURE) begin
                secure_out <= 1'b1;
            end else if (cmd_op == OP_COMPLETE) begin
                complete_out <= 1'b1;
            end
        end
    end

    // user flash read ignores the security bit
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rd_data <= '0;
        end else if (new_cmd && cmd_op == OP_READ_CFG) begin
            rd_data <= secure_out ? '0 : cfg_flash[cmd_addr];
        end else if (new_cmd && cmd_op == OP_READ_USR) begin
            rd_data <= usr_flash[cmd_addr];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            uf_rdata_out <= '0;
        end else begin
            uf_rdata_out <= usr_flash[uf_addr_in];
        end
    end

    // reset acts as power-up: the image loads from flash after it
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            reloading_out  <= 1'b1;
            cfg_cnt        <= '0;
            design_sig_out <= SIG_RESET;
        end else if (reloading_out) begin
            if (cfg_cnt == 32'(TCFG_CYC - 1)) begin
                reloading_out  <= 1'b0;
                design_sig_out <= cfg_flash[0];
            end
            cfg_cnt <= cfg_cnt + 32'h1;
        end else if (new_cmd && isp_mode_out && cmd_op == OP_RELOAD) begin
            reloading_out <= 1'b1;
            cfg_cnt       <= '0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            isp_mode_out <= 1'b0;
        end else if (new_cmd && cmd_op == OP_ENTER && !reloading_out) begin
            isp_mode_out <= 1'b1;
        end else if (new_cmd && (cmd_op == OP_EXIT || cmd_op == OP_RELOAD)) begin
            isp_mode_out <= 1'b0;
        end
    end

    // selections must be shifted in before the clamp instruction fires
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            clamp_sel <= '0;
            clamp_on  <= 1'b0;
            held_lvl  <= '0;
            was_out   <= '0;
        end else if (new_cmd && cmd_op == OP_LOAD_CLAMP) begin
            clamp_sel <= cmd_dr[2*NPIN-1:0];
        end else if (new_cmd && cmd_op == OP_CLAMP_ON && !isp_mode_out) begin
            clamp_on <= 1'b1;
            held_lvl <= pin_s;
            was_out  <= user_oe_in;
        end else if (new_cmd && (cmd_op == OP_EXIT || cmd_op == OP_RELOAD)) begin
            clamp_on <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pin drive
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pin_out        <= '0;
            pin_oe_out     <= '0;
            pin_pullup_out <= '1;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (reloading_out) begin
                    pin_out[i]        <= 1'b0;
                    pin_oe_out[i]     <= 1'b0;
                    pin_pullup_out[i] <= 1'b1;
                end else if (isp_mode_out && clamp_on) begin
                    pin_pullup_out[i] <= 1'b1;
                    case (clamp_sel[2*i +: 2])
                        CLAMP_SAMPLE: begin
                            pin_out[i]    <= held_lvl[i];
                            pin_oe_out[i] <= was_out[i];
                        end
                        CLAMP_HIGH: begin
                            pin_out[i]    <= 1'b1;
                            pin_oe_out[i] <= 1'b1;
                        end
                        CLAMP_LOW: begin
                            pin_out[i]    <= 1'b0;
                            pin_oe_out[i] <= 1'b1;
                        end
                        default: begin
                            pin_out[i]    <= 1'b0;
                            pin_oe_out[i] <= 1'b0;
                        end
                    endcase
                end else if (isp_mode_out || !complete_out) begin
                    pin_out[i]        <= 1'b0;
                    pin_oe_out[i]     <= 1'b0;
                    pin_pullup_out[i] <= 1'b1;
                end else begin
                    pin_out[i]        <= user_data_in[i];
                    pin_oe_out[i]     <= user_oe_in[i];
                    pin_pullup_out[i] <= 1'b0;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_float_in_isp: assert property (
        @(posedge clock_in) disable iff (rst_in)
        isp_mode_out && !clamp_on
        |=> pin_oe_out == '0 && pin_pullup_out == '1)
        else $error("pins driven in programming without clamp");
    a_clamp_high: assert property (
        @(posedge clock_in) disable iff (rst_in)
        isp_mode_out && clamp_on && !reloading_out
        && clamp_sel[3:2] == CLAMP_HIGH
        |=> pin_oe_out[1] && pin_out[1])
        else $error("pin 1 not forced high");
    a_clamp_sample: assert property (
        @(posedge clock_in) disable iff (rst_in)
        isp_mode_out && clamp_on && !reloading_out
        && clamp_sel[1:0] == CLAMP_SAMPLE
        |=> pin_oe_out[0] == was_out[0] && pin_out[0] == held_lvl[0])
        else $error("pin 0 sample not held");
    a_reload_float: assert property (
        @(posedge clock_in) disable iff (rst_in)
        reloading_out |=> pin_oe_out == '0)
        else $error("pin driven during reload");
    a_reload_len: assert property (
        @(posedge clock_in) disable iff (rst_in)
        $rose(reloading_out) |-> reloading_out [*8])
        else $error("reload ended too soon");
    a_secure_read: assert property (
        @(posedge clock_in) disable iff (rst_in)
        new_cmd && cmd_op == OP_READ_CFG && secure_out |=> rd_data == '0)
        else $error("config flash read while secured");
    a_secure_sticky: assert property (
        @(posedge clock_in) disable iff (rst_in)
        $fell(secure_out) |-> $past(new_cmd) && $past(cmd_op) == OP_ERASE_CFG)
        else $error("security bit cleared without erase");
    a_user_read: assert property (
        @(posedge clock_in) disable iff (rst_in)
        new_cmd && cmd_op == OP_READ_USR
        |=> rd_data == $past(usr_flash[cmd_addr]))
        else $error("user flash read blocked");
    a_not_complete: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !complete_out && !(isp_mode_out && clamp_on) |=> pin_oe_out == '0)
        else $error("pin driven before completion bit");
    a_image_hold: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !reloading_out && !$past(reloading_out) |-> $stable(design_sig_out))
        else $error("running image changed without reload");
endmodule // iics_top

// file: iics_jtag_model.sv
`timescale 1ns/100ps
module iics_jtag_model (
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out,
    input  wire logic tdo_in
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////////
    // the link clock rests low between frames, so no edge comes unasked
    task automatic step(input logic m, input logic v);
        tms_out = m;
        tdi_out = v;
        #24 tck_out = 1'b1;
        #24 tck_out = 1'b0;
    endtask
    // an unused data line toggles so a stale level never passes for data
    task automatic run(input int n, input logic m);
        for (int i = 0; i < n; i++) begin
            step(m, ~tdi_out);
        end
    endtask
    task automatic shift(input int n, input logic [15:0] v,
                         output logic [15:0] q);
        q = 16'h0000;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i]);
            q[i] = tdo_in;
        end
        step(1'b1, ~tdi_out);
        // twelve idle clocks after every shift let the request cross and its acknowledge return
        run(12, 1'b0);
    endtask
    task automatic ir(input logic [3:0] op);
        logic [15:0] q;
        run(2, 1'b1);
        run(2, 1'b0);
        shift(4, {12'h000, op}, q);
    endtask
    task automatic dr(input logic [15:0] v, output logic [15:0] q);
        run(1, 1'b1);
        run(2, 1'b0);
        shift(16, v, q);
    endtask
endmodule // iics_jtag_model

// file: tb.sv
`timescale 1ns/100ps
module tb;
    import iics_pkg::*;
    localparam int TC = 20;
    // program pulse of 75 us at the 48 ns link clock
    localparam int PULSE_TCK = 1563;
    logic        toe;
    logic        clock_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        tck, tms, tdi, tdo, uf_wr, reloading, isp, secure, complete;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pu, user_data, user_oe;
    logic [7:0]  uf_wdata, uf_rdata, dsig, eo, ev, d;
    logic [2:0]  uf_addr, a;
    logic [15:0] q, cw;
    logic [1:0]  e2;
    int          seed, num_errors, samples_checked, cycles;

    iics_top #(.NPIN(8), .DEPTH(8), .TCFG_CYC(TC)) u_iics_top (
        .clock_in(clock_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(toe), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_out(pin_oe), .pin_pullup_out(pin_pu),
        .user_data_in(user_data), .user_oe_in(user_oe),
        .uf_addr_in(uf_addr), .uf_wr_in(uf_wr), .uf_wdata_in(uf_wdata),
        .uf_rdata_out(uf_rdata), .design_sig_out(dsig),
        .reloading_out(reloading), .isp_mode_out(isp),
        .secure_out(secure), .complete_out(complete));
    iics_jtag_model u_jtag (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .tdo_in(tdo));

    always #50 clock_in = ~clock_in;
    // the whole run needs some 3600 cycles
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [1:0] clamp_exp(input logic [1:0] c,
                                             input logic o, input logic v);
        case (c)
            CLAMP_SAMPLE: return {o, v & o};
            CLAMP_HIGH:   return 2'b11;
            CLAMP_LOW:    return 2'b10;
            default:      return 2'b00;
        endcase
    endfunction
    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic drive(input logic [7:0] om, input logic [7:0] oz);
        logic [7:0] v;
        v = 8'($random(seed));
        @(posedge clock_in);
        user_data <= v;
        pin_in <= v;
        user_oe <= (8'($random(seed)) | om) & ~oz;
        settle(6);
    endtask
    task automatic pins(input logic [7:0] o, input logic [7:0] v);
        chk("pin_oe", {8'h00, o}, {8'h00, pin_oe});
        chk("pin_out", {8'h00, v & o}, {8'h00, pin_out & pin_oe});
    endtask
    task automatic flt();
        pins(8'h00, 8'h00);
        chk("pin_pullup", 16'h00FF, {8'h00, pin_pu});
    endtask
    task automatic uf_io(input logic [2:0] ad, input logic [7:0] w,
                         input logic [7:0] e);
        @(posedge clock_in);
        uf_addr <= ad;
        uf_wdata <= w;
        uf_wr <= 1'b1;
        @(posedge clock_in);
        uf_wr <= 1'b0;
        settle(3);
        chk("uf_rdata", {8'h00, e}, {8'h00, uf_rdata});
    endtask
    task automatic pg(input logic [3:0] op, input logic [2:0] ad,
                      input logic [7:0] v);
        u_jtag.ir(op);
        u_jtag.dr({5'h00, ad, v}, q);
        u_jtag.run(PULSE_TCK, 1'b0);
    endtask
    task automatic rd(input logic [3:0] op, input logic [2:0] ad,
                      input logic [7:0] e);
        u_jtag.ir(op);
        u_jtag.dr({5'h00, ad, 8'h00}, q);
        u_jtag.dr(16'h0000, q);
        chk("tdo_read", {8'h00, e}, {8'h00, q[7:0]});
        chk("tdo_oe", 16'h0000, {15'h0, toe});
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 63;
        {pin_in, user_data, user_oe, uf_wdata, uf_addr, uf_wr} = '0;
        fork
            u_jtag.run(8, 1'b1);
            repeat (16) @(posedge clock_in);
        join
        rst_in <= 1'b0;
        settle(2);
        chk("reloading", 16'h0001, {15'h0, reloading});
        flt();
        settle(TC + 10);
        chk("load_done", 16'h00FF, {reloading, 7'h00, dsig});
        drive(8'hFF, 8'h00);
        flt();
        a = 3'($random(seed));
        d = 8'($random(seed));
        uf_io(a, d, d);
        u_jtag.run(4, 1'b1);
        u_jtag.run(1, 1'b0);
        u_jtag.ir(OP_ENTER);
        chk("isp_mode", 16'h0001, {15'h0, isp});
        flt();
        u_jtag.ir(OP_COMPLETE);
        u_jtag.ir(OP_EXIT);
        settle(4);
        chk("mode_bits", 16'h0001, {14'h0, isp, complete});
        pins(user_oe, user_data);
        // pins 0..3 take every code; pin 4 samples an undriven pin
        cw = {6'($random(seed)), 2'b00, 8'b11100100};
        drive(8'h01, 8'h10);
        for (int i = 0; i < 8; i++) begin
            e2 = clamp_exp(cw[2*i+:2], user_oe[i], user_data[i]);
            eo[i] = e2[1];
            ev[i] = e2[0];
        end
        u_jtag.ir(OP_LOAD_CLAMP);
        u_jtag.dr(cw, q);
        u_jtag.ir(OP_CLAMP_ON);
        u_jtag.ir(OP_ENTER);
        drive(8'h00, 8'h00);
        pins(eo, ev);
        u_jtag.ir(OP_ERASE_CFG);
        d = 8'($random(seed));
        pg(OP_PROG_CFG, 3'h0, d);
        rd(OP_READ_CFG, 3'h0, d);
        chk("design_sig", 16'h00FF, {reloading, 7'h00, dsig});
        pins(eo, ev);
        u_jtag.ir(OP_COMPLETE);
        u_jtag.ir(OP_SECURE);
        chk("secure", 16'h0001, {15'h0, secure});
        rd(OP_READ_CFG, 3'h0, 8'h00);
        u_jtag.ir(OP_ERASE_USR);
        d = 8'($random(seed));
        pg(OP_PROG_USR, a, d);
        rd(OP_READ_USR, a, d);
        uf_io(a, 8'hFF, d);
        pg(OP_PROG_CFG, 3'h0, 8'h00);
        u_jtag.ir(OP_COMPLETE);
        u_jtag.ir(OP_EXIT);
        u_jtag.ir(OP_ENTER);
        chk("secure_held", 16'h0001, {15'h0, secure});
        u_jtag.ir(OP_ERASE_CFG);
        chk("secure_erased", 16'h0000, {15'h0, secure});
        rd(OP_READ_CFG, 3'h0, FLASH_ERASED);
        d = 8'($random(seed));
        pg(OP_PROG_CFG, 3'h0, d);
        u_jtag.ir(OP_COMPLETE);
        u_jtag.ir(OP_RELOAD);
        chk("reloading", 16'h0001, {15'h0, reloading});
        flt();
        settle(TC + 10);
        chk("design_sig", {8'h00, d}, {reloading, isp, 6'h00, dsig});
        pins(user_oe, user_data);
        final_report();
    end
endmodule // tb
